// ==== common/psdio_pkg.sv ====
/*
  shared constants and carrier types of the pipelined sram data path.
  assumes nothing beyond a single rising-edge clock in the user.
*/
`default_nettype none

package psdio_pkg;

  // geometry of one word: four byte lanes, each eight data and one parity
  localparam int PSDIO_ADDR_W = 18;
  localparam int PSDIO_LANES = 4;
  localparam int PSDIO_BYTE_W = 8;
  localparam int PSDIO_LANE_W = 9;
  localparam int PSDIO_DATA_W = PSDIO_LANES * PSDIO_BYTE_W;
  localparam int PSDIO_WORD_W = PSDIO_LANES * PSDIO_LANE_W;

  // burst counter covers the two low address bits
  localparam int PSDIO_BURST_W = 2;
  localparam logic [1:0] PSDIO_BURST_RST = 2'h0;
  localparam logic [1:0] PSDIO_BURST_STEP = 2'h1;

  // burst order encoding and its value when the strap floats
  localparam logic PSDIO_ORDER_LINEAR = 1'b0;
  localparam logic PSDIO_ORDER_INTERLEAVED = 1'b1;
  localparam logic PSDIO_ORDER_RST = PSDIO_ORDER_INTERLEAVED;

  // pin levels after reset (output enable pin idles high)
  localparam logic PSDIO_OE_N_RST = 1'b1;
  localparam logic PSDIO_DRIVE_RST = 1'b0;

  // one pipelined operation as it moves from stage to stage
  typedef struct packed {
    logic valid;
    logic write;
    logic [PSDIO_ADDR_W-1:0] addr;
    logic [PSDIO_LANES-1:0] byte_write_select_n;
  } psdio_op_s;

  localparam psdio_op_s PSDIO_OP_IDLE = '{
    valid: 1'b0,
    write: 1'b0,
    addr: '0,
    byte_write_select_n: 4'hf
  };

endpackage

`default_nettype wire

// ==== hw/psdio_mem.sv ====
/*
  byte-lane memory of the sram core with a registered read port.
  assumes one clock; a write and a read to the same word on one edge
  returns the freshly written lanes.
*/
`timescale 1ns/100ps
`default_nettype none

module psdio_mem
  import psdio_pkg::*;
#(
  parameter int ADDR_W = PSDIO_ADDR_W,
  parameter int LANES = PSDIO_LANES,
  parameter int LANE_W = PSDIO_LANE_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic re,
  input wire logic [ADDR_W-1:0] raddr,
  input wire logic [LANES-1:0] we,
  input wire logic [ADDR_W-1:0] waddr,
  input wire logic [LANES*LANE_W-1:0] wdata,
  output logic [LANES*LANE_W-1:0] rdata
);

  localparam int DEPTH = 1 << ADDR_W;

  logic same;

  assign same = (waddr == raddr);

  // one array per lane so a masked lane keeps its old contents
  for (genvar b = 0; b < LANES; b++) begin : g_lane
    logic [LANE_W-1:0] mem [0:DEPTH-1];
    logic [LANE_W-1:0] rd_q;

    // write port takes the lane only when its select is active
    always_ff @(posedge clock) begin
      if (we[b]) begin
        mem[waddr] <= wdata[b*LANE_W +: LANE_W];
      end
    end

    // bypass keeps a back-to-back write then read coherent
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        rd_q <= '0;
      end else if (re) begin
        rd_q <= (we[b] && same) ? wdata[b*LANE_W +: LANE_W] : mem[raddr];
      end
    end

    assign rdata[b*LANE_W +: LANE_W] = rd_q;

    AST_WRITE_THROUGH: assert property (
      @(posedge clock) disable iff (!rst_b)
      (re && we[b] && same) |=>
        (rd_q == $past(wdata[b*LANE_W +: LANE_W])))
      else $error("written lane not seen by same-edge read");
  end

endmodule

`default_nettype wire

// ==== hw/psdio_burst.sv ====
/*
  two-bit burst address counter, linear or interleaved order.
  assumes load and advance are already qualified by the clock gate
  and never both high.
*/
`timescale 1ns/100ps
`default_nettype none

module psdio_burst
  import psdio_pkg::*;
#(
  parameter int BURST_W = PSDIO_BURST_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic load,
  input wire logic advance,
  input wire logic [BURST_W-1:0] start,
  input wire logic mode,
  output logic [BURST_W-1:0] addr_lo
);

  logic [BURST_W-1:0] base;
  logic [BURST_W-1:0] cnt;

  // base is taken on load, count restarts from zero
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      base <= PSDIO_BURST_RST;
      cnt <= PSDIO_BURST_RST;
    end else if (load) begin
      base <= start;
      cnt <= PSDIO_BURST_RST;
    end else if (advance) begin
      cnt <= cnt + PSDIO_BURST_STEP;
    end
  end

  // wraps after four beats in both orders by width alone
  assign addr_lo = (mode == PSDIO_ORDER_INTERLEAVED) ? (base ^ cnt)
                                                     : (base + cnt);

  AST_BURST_STEP: assert property (
    @(posedge clock) disable iff (!rst_b)
    (advance && !load) |=> (cnt == $past(cnt) + PSDIO_BURST_STEP))
    else $error("burst counter did not step");

  AST_BURST_LOAD: assert property (
    @(posedge clock) disable iff (!rst_b)
    load |=> (cnt == PSDIO_BURST_RST) && (base == $past(start)))
    else $error("burst counter did not load");

endmodule

`default_nettype wire

// ==== hw/psdio_top.sv ====
/*
  pin-level data path of a synchronous pipelined burst sram: clock
  gate, address and control stages, byte-lane write with parity,
  registered output drive and burst order strap.
  assumes the controller drives every synchronous pin from CLOCK; the
  output enable pin and the strap are asynchronous and synchronised.
*/
// Local design decisions: the plain strobed port and the address map.
// Notes on behaviour
// - pipeline edges act only while clock gate low
// - gate high stretches cycle, no deselect
// - write data captured on rising edge
// - read data one stage after address
// - output enable high forces lines off
// - off during write data, after deselect
// - parity lanes follow data lanes exactly
// - parity lane written only with its select
// - strap high interleaved, low linear order
// - floating strap means interleaved order
// - advance steps counter, load starts access
`timescale 1ns/100ps
`default_nettype none

module psdio_top
  import psdio_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CLOCK_GATE_N,
  input wire logic CHIP_SELECT_FIRST_N,
  input wire logic CHIP_SELECT_SECOND,
  input wire logic CHIP_SELECT_THIRD_N,
  input wire logic WRITE_ENABLE_N,
  input wire logic ADVANCE_OR_LOAD,
  input wire logic [PSDIO_LANES-1:0] BYTE_WRITE_SELECT_N,
  input wire logic [PSDIO_ADDR_W-1:0] ADDRESS,
  input wire logic OUTPUT_ENABLE_N,
  input wire logic BURST_ORDER_STRAP,
  input wire logic BURST_ORDER_DRIVEN,
  input wire logic [PSDIO_DATA_W-1:0] DQ_IN,
  output logic [PSDIO_DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  input wire logic [PSDIO_LANES-1:0] PARITY_LANES_IN,
  output logic [PSDIO_LANES-1:0] PARITY_LANES_OUT,
  output logic PARITY_LANES_OE
);

  logic en;
  logic sel;
  logic load;
  logic advance;
  logic strap_eff;
  logic strap_meta;
  logic strap_sync;
  logic mode;
  logic oe_meta;
  logic oe_sync;
  psdio_op_s s1;
  psdio_op_s s2;
  logic [PSDIO_BURST_W-1:0] burst_lo;
  logic [PSDIO_ADDR_W-1:0] rd_addr;
  logic rd_out;
  logic next_rd_out;
  logic mem_re;
  logic [PSDIO_LANES-1:0] mem_we;
  logic [PSDIO_WORD_W-1:0] wr_lanes;
  logic [PSDIO_WORD_W-1:0] rd_lanes;

  // the gate qualifies every pipeline edge; the strap and output enable paths below move without it
  assign en = ~CLOCK_GATE_N;
  assign sel = ~CHIP_SELECT_FIRST_N & CHIP_SELECT_SECOND
               & ~CHIP_SELECT_THIRD_N;
  assign load = en & ~ADVANCE_OR_LOAD;
  assign advance = en & ADVANCE_OR_LOAD;

  // an undriven strap pin reads as its pull-up level
  assign strap_eff = BURST_ORDER_DRIVEN ? BURST_ORDER_STRAP
                                        : PSDIO_ORDER_RST;

  // strap synchroniser; the strap is static so latency is harmless
  always_ff @(posedge CLOCK) begin
    strap_meta <= strap_eff;
    strap_sync <= strap_meta;
  end

  // order is caught during reset and frozen afterwards, so a strap
  // that wanders in operation cannot reorder a burst midway
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      mode <= strap_sync;
    end
  end

  // output enable pin is asynchronous: two flops before any use
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      oe_meta <= PSDIO_OE_N_RST;
      oe_sync <= PSDIO_OE_N_RST;
    end else begin
      oe_meta <= OUTPUT_ENABLE_N;
      oe_sync <= oe_meta;
    end
  end

  // address stage: a load starts a fresh access or a deselect,
  // an advance keeps the latched type and only retakes byte selects
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s1 <= PSDIO_OP_IDLE;
    end else if (load) begin
      s1.valid <= sel;
      s1.write <= ~WRITE_ENABLE_N;
      s1.addr <= ADDRESS;
      s1.byte_write_select_n <= BYTE_WRITE_SELECT_N;
    end else if (advance) begin
      s1.byte_write_select_n <= BYTE_WRITE_SELECT_N;
    end
  end
  // gate high leaves s1 untouched, so a pending access resumes

  // burst low bits replace the latched ones while an access runs
  psdio_burst #(
    .BURST_W(PSDIO_BURST_W)
  ) u_burst (
    .clock(CLOCK),
    .rst_b(RST_B),
    .load(load),
    .advance(advance),
    .start(ADDRESS[PSDIO_BURST_W-1:0]),
    .mode(mode),
    .addr_lo(burst_lo)
  );

  assign rd_addr = {s1.addr[PSDIO_ADDR_W-1:PSDIO_BURST_W], burst_lo};

  // data stage: a write waits here one edge for its data on the pins
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      s2 <= PSDIO_OP_IDLE;
    end else if (en) begin
      s2.valid <= s1.valid;
      s2.write <= s1.write;
      s2.addr <= rd_addr;
      s2.byte_write_select_n <= s1.byte_write_select_n;
    end
  end

  // each lane carries its parity bit with its byte
  for (genvar b = 0; b < PSDIO_LANES; b++) begin : g_pins
    assign wr_lanes[b*PSDIO_LANE_W +: PSDIO_LANE_W] =
      {PARITY_LANES_IN[b], DQ_IN[b*PSDIO_BYTE_W +: PSDIO_BYTE_W]};
    assign DQ_OUT[b*PSDIO_BYTE_W +: PSDIO_BYTE_W] =
      rd_lanes[b*PSDIO_LANE_W +: PSDIO_BYTE_W];
    assign PARITY_LANES_OUT[b] =
      rd_lanes[b*PSDIO_LANE_W + PSDIO_BYTE_W];
  end

  // pins are captured on the edge two after the write command
  assign mem_we = {PSDIO_LANES{en & s2.valid & s2.write}}
                  & ~s2.byte_write_select_n;
  // read only for a live read so the output register holds its word
  assign mem_re = en & s1.valid & ~s1.write;

  psdio_mem #(
    .ADDR_W(PSDIO_ADDR_W),
    .LANES(PSDIO_LANES),
    .LANE_W(PSDIO_LANE_W)
  ) u_mem (
    .clock(CLOCK),
    .rst_b(RST_B),
    .re(mem_re),
    .raddr(rd_addr),
    .we(mem_we),
    .waddr(s2.addr),
    .wdata(wr_lanes),
    .rdata(rd_lanes)
  );

  // drive only behind a read; writes and deselects fall silent,
  // which also covers the first clock after a deselect
  always_comb begin
    next_rd_out = rd_out;
    if (en) begin
      next_rd_out = s1.valid & ~s1.write;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      rd_out <= PSDIO_DRIVE_RST;
    end else begin
      rd_out <= next_rd_out;
    end
  end

  // enables are registered; the output enable pin lags by the
  // synchroniser, a trade for clean timing on this clock
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      DQ_OE <= PSDIO_DRIVE_RST;
      PARITY_LANES_OE <= PSDIO_DRIVE_RST;
    end else begin
      DQ_OE <= next_rd_out & ~oe_sync;
      PARITY_LANES_OE <= next_rd_out & ~oe_sync;
    end
  end

  // checks on the pipeline, all on the one clock
  default clocking cb @(posedge CLOCK);
  endclocking

  default disable iff (!RST_B);

  AST_GATE_FREEZE: assert property (
    CLOCK_GATE_N |=> $stable(s1) && $stable(s2) && $stable(DQ_OUT))
    else $error("state moved while clock gate high");

  AST_GATE_NO_DESELECT: assert property (
    (s1.valid && !s1.write && CLOCK_GATE_N) ##1 !CLOCK_GATE_N
      |=> rd_out)
    else $error("stretched read lost after gate release");

  AST_READ_DRIVE: assert property (
    (en && s1.valid && !s1.write && !oe_sync) |=> DQ_OE && rd_out)
    else $error("read data not driven one edge after address stage");

  AST_OE_OFF: assert property (
    oe_sync |=> !DQ_OE && !PARITY_LANES_OE)
    else $error("lines driven with output enable high");

  AST_WRITE_HIZ: assert property (
    (en && s1.valid && s1.write) |=> !DQ_OE)
    else $error("lines driven during write data cycle");

  // a read loaded on the very next edge may drive one cycle later
  AST_DESELECT_HIZ: assert property (
    (load && !sel) ##1 (en && !(load && sel && WRITE_ENABLE_N))
      |=> !DQ_OE [*2])
    else $error("lines driven after deselect");

  AST_PARITY_OE: assert property (
    PARITY_LANES_OE == DQ_OE)
    else $error("parity enable differs from data enable");

  AST_PARITY_MASK: assert property (
    (en && s1.valid && s1.write) ##1 en |->
      (mem_we == ~$past(s1.byte_write_select_n)))
    else $error("lane write does not follow its byte select");

  AST_STRAP_HOLD: assert property (
    $past(RST_B) |-> $stable(mode))
    else $error("burst order changed outside reset");

  AST_STRAP_FLOAT: assert property (
    ($past(!RST_B) && !$past(BURST_ORDER_DRIVEN, 3))
      |-> mode == PSDIO_ORDER_INTERLEAVED)
    else $error("floating strap not taken as interleaved");

  COV_READ: cover property (
    load && sel && WRITE_ENABLE_N ##1 en ##1 DQ_OE);

  COV_WRITE: cover property (
    load && sel && !WRITE_ENABLE_N ##1 en ##1 (mem_we != '0));

  COV_BURST: cover property (
    load && sel ##1 advance [*3]);

  COV_STRETCH: cover property (
    s1.valid ##1 CLOCK_GATE_N [*3] ##1 en);

endmodule

`default_nettype wire

// ==== tb/psdio_ctrl.sv ====
/*
  memory controller model on the sram pins: controls, write data and
  the far side of the shared data and parity lines.
  assumes the bench calls cyc once per clock; each call waits for the
  next rising edge and changes the pins just after it.
*/
`timescale 1ns/100ps
`default_nettype none
module psdio_ctrl
  import psdio_pkg::*;
(
  input wire logic clock,
  output logic gate_n,
  output logic sel1_n,
  output logic sel2,
  output logic sel3_n,
  output logic we_n,
  output logic advance,
  output logic [PSDIO_LANES-1:0] byte_write_select_n,
  output logic [PSDIO_ADDR_W-1:0] addr,
  input wire logic [PSDIO_DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic [PSDIO_LANES-1:0] par_out,
  input wire logic par_oe,
  output logic [PSDIO_DATA_W-1:0] dq_in,
  output logic [PSDIO_LANES-1:0] par_in,
  output logic clash
);
  logic drv = 1'h0;
  logic [PSDIO_WORD_W-1:0] wval = 36'h0;
  logic [PSDIO_WORD_W-1:0] last = 36'h0;

  // pins start with the gate open and the part deselected
  initial begin
    {gate_n, sel2, advance, clash} = 4'h0;
    {sel1_n, sel3_n, we_n} = 3'h7;
    byte_write_select_n = 4'hf;
    addr = 18'h0_0000;
  end

  // released lines show the inverse of their last level, not a copy
  assign dq_in = dq_oe ? dq_out : (drv ? wval[31:0] : ~last[31:0]);
  assign par_in = par_oe ? par_out : (drv ? wval[35:32] : ~last[35:32]);

  // remember line levels; flag any fight between both drivers
  always @(posedge clock) begin
    last <= {par_in, dq_in};
    if (drv && (dq_oe || par_oe)) begin
      clash <= 1'h1;
    end
  end

  // one bus cycle, all pins change together after the edge
  task automatic cyc(input logic g, input logic s, input logic a,
    input logic w, input logic [3:0] m, input logic [17:0] ad,
    input logic d, input logic [35:0] v);
    @(posedge clock);
    gate_n <= g;
    sel1_n <= ~s;
    sel2 <= s;
    sel3_n <= ~s;
    advance <= a;
    we_n <= w;
    byte_write_select_n <= m;
    addr <= ad;
    drv <= d;
    wval <= v;
  endtask
endmodule
`default_nettype wire

// ==== tb/psdio_top_tb.sv ====
/*
  self-checking bench of the sram data path.
  assumes psdio_ctrl drives the pins and a 50 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module psdio_top_tb
  import psdio_pkg::*;
;
  localparam logic [17:0] A0 = 18'h0_0040;
  localparam logic [17:0] A1 = 18'h0_0041;
  localparam logic [15:0] BH = 16'h0040;
  localparam logic [35:0] W0 = 36'h1_2345_6789;
  localparam logic [35:0] W1 = 36'he_dcba_9876;
  localparam logic [35:0] W2 = 36'h5_a5a5_a5a5;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic strap = 1'h0;
  logic strap_drv = 1'h1;
  logic oe_n = 1'h0;
  logic gate_n, s1_n, s2, s3_n, we_n, advance, oe, poe, clash;
  logic [3:0] byte_write_select_n, pin, pout;
  logic [17:0] addr;
  logic [31:0] din, dout;
  int fails = 0;
  int check_count = 0;
  int i;

  always #10 clock = ~clock;

  psdio_top uut (.CLOCK(clock), .RST_B(rst_b), .CLOCK_GATE_N(gate_n),
    .CHIP_SELECT_FIRST_N(s1_n), .CHIP_SELECT_SECOND(s2),
    .CHIP_SELECT_THIRD_N(s3_n), .WRITE_ENABLE_N(we_n),
    .ADVANCE_OR_LOAD(advance),
    .BYTE_WRITE_SELECT_N(byte_write_select_n), .ADDRESS(addr),
    .OUTPUT_ENABLE_N(oe_n), .BURST_ORDER_STRAP(strap),
    .BURST_ORDER_DRIVEN(strap_drv), .DQ_IN(din), .DQ_OUT(dout),
    .DQ_OE(oe), .PARITY_LANES_IN(pin), .PARITY_LANES_OUT(pout),
    .PARITY_LANES_OE(poe));

  psdio_ctrl u_ctrl (.clock(clock), .gate_n(gate_n), .sel1_n(s1_n),
    .sel2(s2), .sel3_n(s3_n), .we_n(we_n), .advance(advance),
    .byte_write_select_n(byte_write_select_n),
    .addr(addr), .dq_out(dout), .dq_oe(oe), .par_out(pout),
    .par_oe(poe), .dq_in(din), .par_in(pin), .clash(clash));

  task complete_run();
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // word compare; flags reuse it zero-extended
  task chkw(input logic [35:0] exp, input logic [35:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task chkb(input logic exp, input logic got);
    chkw({35'h0, exp}, {35'h0, got});
  endtask

  function logic [35:0] rdv();
    rdv = {pout, dout};
  endfunction

  function logic [35:0] pat(input logic [1:0] k);
    pat = {2'h2, k, 28'hc3c_3000, 2'h1, k};
  endfunction

  // lanes with a low select take the new byte and parity bit
  function logic [35:0] mrg(input logic [35:0] o, input logic [35:0] n,
    input logic [3:0] m);
    for (int b = 0; b < 4; b++) begin
      if (!m[b]) begin
        o[8*b+:8] = n[8*b+:8];
        o[32+b] = n[32+b];
      end
    end
    mrg = o;
  endfunction

  // bus cycle shorthands
  task ds();
    u_ctrl.cyc(1'h0, 1'h0, 1'h0, 1'h1, 4'hf, 18'h0_0000, 1'h0, 36'h0);
  endtask
  task gh();
    u_ctrl.cyc(1'h1, 1'h0, 1'h0, 1'h1, 4'hf, 18'h0_0000, 1'h0, 36'h0);
  endtask
  task av();
    u_ctrl.cyc(1'h0, 1'h0, 1'h1, 1'h1, 4'hf, 18'h0_0000, 1'h0, 36'h0);
  endtask
  task rd(input logic [17:0] a);
    u_ctrl.cyc(1'h0, 1'h1, 1'h0, 1'h1, 4'hf, a, 1'h0, 36'h0);
  endtask
  task wl(input logic [17:0] a, input logic [3:0] m);
    u_ctrl.cyc(1'h0, 1'h1, 1'h0, 1'h0, m, a, 1'h0, 36'h0);
  endtask
  task dat(input logic [35:0] v);
    u_ctrl.cyc(1'h0, 1'h0, 1'h0, 1'h1, 4'hf, 18'h0_0000, 1'h1, v);
  endtask
  // write data goes out two edges after the command
  task wr(input logic [17:0] a, input logic [3:0] m, input logic [35:0] v);
    wl(a, m);
    ds();
    dat(v);
  endtask
  task rdq(input logic [17:0] a);
    rd(a);
    ds();
    ds();
    #1;
  endtask

  // strap moves only while reset is held
  task rst(input logic md, input logic dr);
    @(posedge clock);
    rst_b <= 1'h0;
    strap <= md;
    strap_drv <= dr;
    repeat (20) @(posedge clock);
    rst_b <= 1'h1;
  endtask

  // read then write back to back: turnaround of the shared lines
  task s_turn();
    wr(A0, 4'h0, W0);
    rd(A0);
    wl(A1, 4'h0);
    ds();
    #1;
    chkw(W0, rdv());
    chkb(1'h1, oe);
    dat(W1);
    #1;
    chkb(1'h0, oe);
    chkb(1'h0, poe);
    rdq(A1);
    chkw(W1, rdv());
  endtask

  // masked write with a read of the same word loaded right behind it:
  // the read must see the freshly written lanes through the bypass
  task s_mask();
    wl(A1, 4'ha);
    rd(A1);
    dat(W2);
    ds();
    #1;
    chkw(mrg(W1, W2, 4'ha), rdv());
    rdq(A1);
    chkw(mrg(W1, W2, 4'ha), rdv());
  endtask

  // gated edges freeze a pending read, which then resumes
  task s_gate();
    rd(A0);
    gh();
    gh();
    #1;
    chkb(1'h0, oe);
    ds();
    gh();
    gh();
    #1;
    chkw(W0, rdv());
    chkb(1'h1, oe);
    ds();
  endtask

  // output enable pin acts after its three-edge lag
  task s_oe();
    @(posedge clock);
    oe_n <= 1'h1;
    rdq(A0);
    chkb(1'h0, oe);
    @(posedge clock);
    oe_n <= 1'h0;
  endtask

  task s_burst(input logic md, input logic dr, input logic il);
    logic [1:0] lo;
    rst(md, dr);
    rd({BH, 2'h1});
    for (int k = 0; k < 4; k++) begin
      if (k < 2) begin
        av();
      end else begin
        ds();
      end
      if (k == 0) begin
        av();
      end
      #1;
      lo = il ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
      chkw(pat(lo), rdv());
    end
    ds();
    #1;
    chkb(1'h0, oe);
  endtask

  initial begin
    rst(1'h0, 1'h1);
    s_turn();
    s_mask();
    s_gate();
    s_oe();
    for (i = 0; i < 4; i++) begin
      wr({BH, 2'(i)}, 4'h0, pat(2'(i)));
    end
    s_burst(1'h0, 1'h1, 1'h0);
    s_burst(1'h1, 1'h1, 1'h1);
    s_burst(1'h0, 1'h0, 1'h1);
    chkb(1'h0, clash);
    complete_run();
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
